/* pkg/rpu_pkg.sv */
// Shared constants and types for the region protection unit.
package rpu_pkg;

  // Region count per address space.
  localparam int RPU_REGIONS = 8;

  // Coprocessor register numbers (primary register field).
  localparam logic [3:0] RPU_CRN_CTRL   = 4'h1;
  localparam logic [3:0] RPU_CRN_CACH   = 4'h2;
  localparam logic [3:0] RPU_CRN_BUF    = 4'h3;
  localparam logic [3:0] RPU_CRN_FAULT  = 4'h4;
  localparam logic [3:0] RPU_CRN_PERM   = 4'h5;
  localparam logic [3:0] RPU_CRN_REGION = 4'h6;

  // Secondary opcode selects the data or the instruction set, or the fault status or fault address.
  localparam logic [2:0] RPU_OPC2_DATA  = 3'h0;
  localparam logic [2:0] RPU_OPC2_INST  = 3'h1;
  localparam logic [2:0] RPU_OPC2_FSTAT = 3'h0;
  localparam logic [2:0] RPU_OPC2_FADDR = 3'h1;

  // Field positions.
  localparam int RPU_CTRL_EN_BIT  = 0;
  localparam int RPU_BASE_LSB     = 12;
  localparam int RPU_BASE_MSB     = 31;
  localparam int RPU_SIZE_LSB     = 1;
  localparam int RPU_SIZE_MSB     = 5;
  localparam int RPU_EN_BIT       = 0;
  localparam int RPU_PERM_W       = 2;
  localparam int RPU_FS_DABT_BIT  = 0;
  localparam int RPU_FS_PABT_BIT  = 1;
  localparam int RPU_BASE_W       = RPU_BASE_MSB - RPU_BASE_LSB + 1;

  // Size codes: 4KB at the smallest legal code, 4GB at the largest.
  localparam logic [4:0] RPU_SIZE_MIN = 5'h0b;
  localparam logic [4:0] RPU_SIZE_MAX = 5'h1f;

  // Access permission codes.
  localparam logic [1:0] RPU_AP_NONE    = 2'h0;
  localparam logic [1:0] RPU_AP_PRIV    = 2'h1;
  localparam logic [1:0] RPU_AP_USER_RO = 2'h2;
  localparam logic [1:0] RPU_AP_FULL    = 2'h3;

  // Reset values.
  localparam logic        RPU_CTRL_RESET      = 1'b0;
  localparam logic [7:0]  RPU_REGION_EN_RESET = 8'h00;
  localparam logic [7:0]  RPU_ATTR_RESET      = 8'h00;
  localparam logic [15:0] RPU_PERM_RESET      = 16'h0000;
  localparam logic [19:0] RPU_BASE_RESET      = 20'h00000;
  localparam logic [4:0]  RPU_SIZE_RESET      = 5'h00;
  localparam logic [31:0] RPU_WORD_RESET      = 32'h00000000;

  // Cache and write-buffer behaviour, indexed by {cachable, bufferable}.
  typedef enum logic [1:0] {
    RPU_NCNB,
    RPU_NCB,
    RPU_WT,
    RPU_WB
  } rpu_cache_mode_t;

endpackage

/* rtl/rpu_core.sv */
// Region protection unit: region registers, lookup and abort decision.
`timescale 1ns/1ns
`default_nettype none
module rpu_core
  import rpu_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        cpValid,
  input  wire logic        cpWrite,
  input  wire logic [3:0]  cpCrn,
  input  wire logic [2:0]  cpCrm,
  input  wire logic [2:0]  cpOpc2,
  input  wire logic [31:0] cpWdata,
  output logic [31:0]      cpRdata,
  input  wire logic        instReq,
  input  wire logic [31:0] instAddr,
  input  wire logic        instPriv,
  output logic             instCachable,
  output logic             instAbort,
  input  wire logic        dataReq,
  input  wire logic [31:0] dataAddr,
  input  wire logic        dataPriv,
  input  wire logic        dataWrite,
  output logic             dataCachable,
  output logic             dataBufferable,
  output rpu_cache_mode_t  dataCacheMode,
  output logic             dataAbort,
  output logic             unitActive
);

  typedef struct packed {
    logic                             unitEnable;
    logic [7:0][RPU_BASE_W-1:0]       iBase;
    logic [7:0][4:0]                  iSize;
    logic [7:0]                       iEn;
    logic [7:0][RPU_BASE_W-1:0]       dBase;
    logic [7:0][4:0]                  dSize;
    logic [7:0]                       dEn;
    logic [7:0]                       iCach;
    logic [7:0]                       dCach;
    logic [7:0]                       dBuf;
    logic [7:0][RPU_PERM_W-1:0]       iPerm;
    logic [7:0][RPU_PERM_W-1:0]       dPerm;
    logic                             dAbtSeen;
    logic                             pAbtSeen;
    logic [31:0]                      faultAddr;
    logic [31:0]                      rdata;
  } rpu_state_t;

  rpu_state_t st_reg;
  rpu_state_t st_next;

  logic [7:0]            iHit;
  logic [7:0]            dHit;
  logic                  iFound;
  logic                  dFound;
  logic [2:0]            iSel;
  logic [2:0]            dSel;
  logic [RPU_PERM_W-1:0] iPermSel;
  logic [RPU_PERM_W-1:0] dPermSel;
  logic [31:0]           readWord;

  // Permission check shared by both address spaces.
  function automatic logic rpu_allowed(input logic [1:0] perm,
                                       input logic       priv,
                                       input logic       wr);
    logic ok;
    ok = 1'b0;
    case (perm)
      RPU_AP_NONE:    ok = 1'b0;
      RPU_AP_PRIV:    ok = priv;
      RPU_AP_USER_RO: ok = priv | ~wr;
      RPU_AP_FULL:    ok = 1'b1;
      default:        ok = 1'b0;
    endcase
    return ok;
  endfunction

  // One comparator per region in each set.
  for (genvar gi = 0; gi < RPU_REGIONS; gi++) begin : g_region
    rpu_region_match u_inst_match (
      .addr     (instAddr),
      .base     (st_reg.iBase[gi]),
      .sizeCode (st_reg.iSize[gi]),
      .enable   (st_reg.iEn[gi]),
      .hit      (iHit[gi])
    );
    rpu_region_match u_data_match (
      .addr     (dataAddr),
      .base     (st_reg.dBase[gi]),
      .sizeCode (st_reg.dSize[gi]),
      .enable   (st_reg.dEn[gi]),
      .hit      (dHit[gi])
    );
  end

  // Lookup runs straight from the address so no cycle is lost per access.
  always_comb begin
    iFound = 1'b0;
    dFound = 1'b0;
    iSel   = 3'h0;
    dSel   = 3'h0;
    for (int n = 0; n < RPU_REGIONS; n++) begin
      if (iHit[n]) begin
        iFound = 1'b1;
        iSel   = 3'(n);
      end
      if (dHit[n]) begin
        dFound = 1'b1;
        dSel   = 3'(n);
      end
    end
    iPermSel = st_reg.iPerm[iSel];
    dPermSel = st_reg.dPerm[dSel];
    unitActive = st_reg.unitEnable;
    instCachable = st_reg.unitEnable & iFound &
                   st_reg.iCach[iSel];
    dataCachable = st_reg.unitEnable & dFound &
                   st_reg.dCach[dSel];
    dataBufferable = st_reg.unitEnable & dFound &
                     st_reg.dBuf[dSel];
    dataCacheMode = rpu_cache_mode_t'({dataCachable,
                                       dataBufferable});
    // Fetches go through the shared check as reads, never as writes.
    instAbort = instReq & st_reg.unitEnable &
                (~iFound | ~rpu_allowed(iPermSel, instPriv,
                                        1'b0));
    dataAbort = dataReq & st_reg.unitEnable &
                (~dFound | ~rpu_allowed(dPermSel, dataPriv,
                                        dataWrite));
  end

  // Register read multiplexer; unmapped reads return zero.
  always_comb begin
    readWord = RPU_WORD_RESET;
    case (cpCrn)
      RPU_CRN_CTRL: begin
        readWord[RPU_CTRL_EN_BIT] = st_reg.unitEnable;
      end
      RPU_CRN_CACH: begin
        if (cpOpc2 == RPU_OPC2_DATA) begin
          readWord[7:0] = st_reg.dCach;
        end else if (cpOpc2 == RPU_OPC2_INST) begin
          readWord[7:0] = st_reg.iCach;
        end
      end
      RPU_CRN_BUF: begin
        // The instruction set has no bufferable bits, so that read is zero.
        if (cpOpc2 == RPU_OPC2_DATA) begin
          readWord[7:0] = st_reg.dBuf;
        end
      end
      RPU_CRN_PERM: begin
        if (cpOpc2 == RPU_OPC2_DATA) begin
          readWord[15:0] = st_reg.dPerm;
        end else if (cpOpc2 == RPU_OPC2_INST) begin
          readWord[15:0] = st_reg.iPerm;
        end
      end
      RPU_CRN_REGION: begin
        if (cpOpc2 == RPU_OPC2_DATA) begin
          readWord[RPU_BASE_MSB:RPU_BASE_LSB] = st_reg.dBase[cpCrm];
          readWord[RPU_SIZE_MSB:RPU_SIZE_LSB] = st_reg.dSize[cpCrm];
          readWord[RPU_EN_BIT] = st_reg.dEn[cpCrm];
        end else if (cpOpc2 == RPU_OPC2_INST) begin
          readWord[RPU_BASE_MSB:RPU_BASE_LSB] = st_reg.iBase[cpCrm];
          readWord[RPU_SIZE_MSB:RPU_SIZE_LSB] = st_reg.iSize[cpCrm];
          readWord[RPU_EN_BIT] = st_reg.iEn[cpCrm];
        end
      end
      RPU_CRN_FAULT: begin
        if (cpOpc2 == RPU_OPC2_FSTAT) begin
          readWord[RPU_FS_DABT_BIT] = st_reg.dAbtSeen;
          readWord[RPU_FS_PABT_BIT] = st_reg.pAbtSeen;
        end else if (cpOpc2 == RPU_OPC2_FADDR) begin
          readWord = st_reg.faultAddr;
        end
      end
      default: readWord = RPU_WORD_RESET;
    endcase
  end

  // Next-state logic: register writes, read capture, fault capture.
  always_comb begin
    st_next = st_reg;
    if (cpValid && cpWrite) begin
      case (cpCrn)
        RPU_CRN_CTRL: begin
          st_next.unitEnable = cpWdata[RPU_CTRL_EN_BIT];
        end
        RPU_CRN_CACH: begin
          if (cpOpc2 == RPU_OPC2_DATA) begin
            st_next.dCach = cpWdata[7:0];
          end else if (cpOpc2 == RPU_OPC2_INST) begin
            st_next.iCach = cpWdata[7:0];
          end
        end
        RPU_CRN_BUF: begin
          // Instruction regions have no bufferable attribute.
          if (cpOpc2 == RPU_OPC2_DATA) begin
            st_next.dBuf = cpWdata[7:0];
          end
        end
        RPU_CRN_PERM: begin
          if (cpOpc2 == RPU_OPC2_DATA) begin
            st_next.dPerm = cpWdata[15:0];
          end else if (cpOpc2 == RPU_OPC2_INST) begin
            st_next.iPerm = cpWdata[15:0];
          end
        end
        RPU_CRN_REGION: begin
          // Size codes below the minimum are stored as written; the
          // comparator then treats them as 4KB regions, the same as the minimum code.
          if (cpOpc2 == RPU_OPC2_DATA) begin
            st_next.dBase[cpCrm] =
              cpWdata[RPU_BASE_MSB:RPU_BASE_LSB];
            st_next.dSize[cpCrm] =
              cpWdata[RPU_SIZE_MSB:RPU_SIZE_LSB];
            st_next.dEn[cpCrm] = cpWdata[RPU_EN_BIT];
          end else if (cpOpc2 == RPU_OPC2_INST) begin
            st_next.iBase[cpCrm] =
              cpWdata[RPU_BASE_MSB:RPU_BASE_LSB];
            st_next.iSize[cpCrm] =
              cpWdata[RPU_SIZE_MSB:RPU_SIZE_LSB];
            st_next.iEn[cpCrm] = cpWdata[RPU_EN_BIT];
          end
        end
        RPU_CRN_FAULT: begin
          // Write one to clear a sticky abort flag.
          if (cpOpc2 == RPU_OPC2_FSTAT) begin
            if (cpWdata[RPU_FS_DABT_BIT]) begin
              st_next.dAbtSeen = 1'b0;
            end
            if (cpWdata[RPU_FS_PABT_BIT]) begin
              st_next.pAbtSeen = 1'b0;
            end
          end
        end
        default: st_next.rdata = st_reg.rdata;
      endcase
    end
    if (cpValid && !cpWrite) begin
      st_next.rdata = readWord;
    end
    // New aborts come after the clear so that a same-cycle event is kept.
    if (instAbort) begin
      st_next.pAbtSeen  = 1'b1;
      st_next.faultAddr = instAddr;
    end
    if (dataAbort) begin
      st_next.dAbtSeen  = 1'b1;
      st_next.faultAddr = dataAddr;
    end
    if (srst) begin
      st_next            = '0;
      st_next.unitEnable = RPU_CTRL_RESET;
      st_next.iEn        = RPU_REGION_EN_RESET;
      st_next.dEn        = RPU_REGION_EN_RESET;
      st_next.iCach      = RPU_ATTR_RESET;
      st_next.dCach      = RPU_ATTR_RESET;
      st_next.dBuf       = RPU_ATTR_RESET;
      st_next.iPerm      = RPU_PERM_RESET;
      st_next.dPerm      = RPU_PERM_RESET;
      st_next.faultAddr  = RPU_WORD_RESET;
      st_next.rdata      = RPU_WORD_RESET;
      st_next.dAbtSeen   = 1'b0;
      st_next.pAbtSeen   = 1'b0;
      // Only the enables must reset; bases and sizes are cleared as well so
      // that a read before the first write shows a defined value.
      for (int r = 0; r < RPU_REGIONS; r++) begin
        st_next.iBase[r] = RPU_BASE_RESET;
        st_next.dBase[r] = RPU_BASE_RESET;
        st_next.iSize[r] = RPU_SIZE_RESET;
        st_next.dSize[r] = RPU_SIZE_RESET;
      end
    end
  end

  always_ff @(posedge mclk) begin
    st_reg <= st_next;
  end

  assign cpRdata = st_reg.rdata;

endmodule
`default_nettype wire

/* rtl/rpu_region_match.sv */
// Address comparator for one protection region.
`timescale 1ns/1ns
`default_nettype none
module rpu_region_match
  import rpu_pkg::*;
(
  input  wire logic [31:0]         addr,
  input  wire logic [RPU_BASE_W-1:0] base,
  input  wire logic [4:0]          sizeCode,
  input  wire logic                enable,
  output logic                     hit
);

  logic [RPU_BASE_W-1:0] care;

  // Only address bits above the region size take part in the compare.
  always_comb begin
    for (int j = 0; j < RPU_BASE_W; j++) begin
      care[j] = (5'(j + RPU_BASE_LSB) > sizeCode);
    end
    hit = enable &&
          (((addr[RPU_BASE_MSB:RPU_BASE_LSB] ^ base) & care) ==
           RPU_BASE_RESET);
  end

endmodule
`default_nettype wire

/* testbench/region_protection_unit_tb_top.sv */
// Self-checking bench for the region protection unit.
`timescale 1ns/1ns
`default_nettype none
module region_protection_unit_tb_top
  import rpu_pkg::*;
;
  logic            mclk = 1'b0;
  logic            srst = 1'b1;
  logic            cpValid = 1'b0;
  logic            cpWrite = 1'b0;
  logic [3:0]      cpCrn = 4'h0;
  logic [2:0]      cpCrm = 3'h0;
  logic [2:0]      cpOpc2 = 3'h0;
  logic [31:0]     cpWdata = 32'h00000000;
  logic [31:0]     cpRdata, instAddr, dataAddr;
  logic            instReq, instPriv, instCachable, instAbort, rdSeen;
  logic            dataReq, dataPriv, dataWrite, dataCachable;
  logic            dataBufferable, dataAbort, unitActive;
  rpu_cache_mode_t dataCacheMode;
  logic [31:0]     q[$];
  int              errCount = 0;
  int              compares = 0;
  int              cyc = 0;
  always #2 mclk = ~mclk;
  rpu_core u_dut (.mclk, .srst, .cpValid, .cpWrite, .cpCrn, .cpCrm, .cpOpc2,
    .cpWdata, .cpRdata, .instReq, .instAddr, .instPriv, .instCachable,
    .instAbort, .dataReq, .dataAddr, .dataPriv, .dataWrite, .dataCachable,
    .dataBufferable, .dataCacheMode, .dataAbort, .unitActive);
  rpu_cpu_model u_cpu (.mclk, .instReq, .instAddr, .instPriv, .dataReq,
    .dataAddr, .dataPriv, .dataWrite);
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic cp(input logic w, input logic [3:0] n,
                    input logic [2:0] m, o, input logic [31:0] d);
    @(posedge mclk);
    #1;
    {cpValid, cpWrite, cpCrn, cpCrm, cpOpc2, cpWdata} = {1'b1, w, n, m, o, d};
    @(posedge mclk);
    #1;
    cpValid = 1'b0;
    cpWdata = ~cpWdata;
  endtask
  task automatic rd(input logic [3:0] n, input logic [2:0] m, o,
                    input logic [31:0] e);
    q.push_back(e);
    cp(1'b0, n, m, o, 32'h0);
  endtask
  // Expected value is {abort, attributes}; attributes read 0 on an abort.
  task automatic acc(input logic d, input logic [31:0] a, input logic p, w,
                     input logic [2:0] e);
    q.push_back({29'h0, e});
    u_cpu.access(d, a, p, w);
  endtask
  always @(posedge mclk) rdSeen <= cpValid & ~cpWrite;
  always @(negedge mclk) begin
    if (rdSeen === 1'b1) begin
      chk("rdata", cpRdata, q.pop_front());
    end
    if (dataReq) begin
      chk("data", {29'h0, dataAbort, dataAbort ? 2'h0 : dataCacheMode},
          q.pop_front());
    end
    if (instReq) begin
      chk("fetch", {30'h0, instAbort, instCachable & ~instAbort},
          q.pop_front());
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 5000) begin
      errCount++;
      closeOut();
    end
  end
  initial begin
    void'($urandom(32'heb1be61b));
    repeat (8) @(posedge mclk);
    #1;
    srst = 1'b0;
    rd(RPU_CRN_REGION, 3'h7, RPU_OPC2_DATA, 32'h0);
    acc(1'b1, $urandom, 1'b0, 1'b1, 3'h0);
    cp(1'b1, RPU_CRN_REGION, 3'h7, RPU_OPC2_DATA, 32'hffffffff);
    rd(RPU_CRN_REGION, 3'h7, RPU_OPC2_DATA, 32'hfffff03f);
    cp(1'b1, RPU_CRN_REGION, 3'h7, RPU_OPC2_DATA, 32'h0);
    // Both background regions go in first so the unit never comes up empty.
    cp(1'b1, RPU_CRN_REGION, 3'h0, RPU_OPC2_DATA, 32'h3f);
    cp(1'b1, RPU_CRN_REGION, 3'h0, RPU_OPC2_INST, 32'h3f);
    cp(1'b1, RPU_CRN_REGION, 3'h1, RPU_OPC2_DATA, 32'h1b);
    cp(1'b1, RPU_CRN_REGION, 3'h2, RPU_OPC2_DATA, 32'h3017);
    cp(1'b1, RPU_CRN_PERM, 3'h0, RPU_OPC2_DATA, 32'h27);
    cp(1'b1, RPU_CRN_PERM, 3'h0, RPU_OPC2_INST, 32'h1);
    rd(RPU_CRN_PERM, 3'h0, RPU_OPC2_DATA, 32'h27);
    cp(1'b1, RPU_CRN_BUF, 3'h0, RPU_OPC2_INST, 32'hff);
    rd(RPU_CRN_BUF, 3'h0, RPU_OPC2_INST, 32'h0);
    cp(1'b1, RPU_CRN_CTRL, 3'h0, RPU_OPC2_DATA, 32'h1);
    rd(RPU_CRN_CTRL, 3'h0, RPU_OPC2_DATA, 32'h1);
    for (int i = 0; i < 4; i++) begin
      cp(1'b1, RPU_CRN_CACH, 3'h0, RPU_OPC2_DATA, 32'(i / 2));
      cp(1'b1, RPU_CRN_BUF, 3'h0, RPU_OPC2_DATA, 32'(i % 2));
      cp(1'b1, RPU_CRN_CACH, 3'h0, RPU_OPC2_INST, 32'(i / 2));
      acc(1'b1, {4'h1, 28'($urandom)}, 1'b0, 1'($urandom), 3'(i));
      acc(1'b0, {4'h1, 28'($urandom)}, 1'b1, 1'b0, 3'(i / 2));
    end
    acc(1'b1, {20'h00003, 12'($urandom)}, 1'b0, 1'b0, 3'h0);
    acc(1'b1, 32'h3010, 1'b0, 1'b1, 3'h4);
    acc(1'b1, 32'h1000, 1'b0, 1'b0, 3'h4);
    acc(1'b1, 32'h1000, 1'b1, 1'b1, 3'h0);
    acc(1'b0, 32'h100, 1'b0, 1'b0, 3'h2);
    acc(1'b0, 32'h100, 1'b1, 1'b0, 3'h1);
    cp(1'b1, RPU_CRN_REGION, 3'h0, RPU_OPC2_DATA, 32'h3e);
    acc(1'b1, {4'h1, 28'($urandom)}, 1'b1, 1'b0, 3'h4);
    cp(1'b1, RPU_CRN_REGION, 3'h2, RPU_OPC2_DATA, 32'h3016);
    acc(1'b1, 32'h3010, 1'b0, 1'b0, 3'h4);
    for (int s = 11; s < 31; s++) begin
      cp(1'b1, RPU_CRN_REGION, 3'h1, RPU_OPC2_DATA, 32'(2 * s + 1));
      acc(1'b1, (32'h2 << s) - 32'h1, 1'b1, 1'b0, 3'h0);
      acc(1'b1, 32'h2 << s, 1'b1, 1'b0, 3'h4);
    end
    rd(RPU_CRN_FAULT, 3'h0, RPU_OPC2_FADDR, 32'h80000000);
    rd(RPU_CRN_FAULT, 3'h0, RPU_OPC2_FSTAT, 32'h3);
    cp(1'b1, RPU_CRN_FAULT, 3'h0, RPU_OPC2_FSTAT, 32'h1);
    rd(RPU_CRN_FAULT, 3'h0, RPU_OPC2_FSTAT, 32'h2);
    cp(1'b1, RPU_CRN_CTRL, 3'h0, RPU_OPC2_DATA, 32'h0);
    acc(1'b1, 32'h3010, 1'b0, 1'b1, 3'h0);
    acc(1'b0, 32'h100, 1'b0, 1'b0, 3'h0);
    repeat (2) @(posedge mclk);
    chk("queue", 32'(q.size()), 32'h0);
    closeOut();
  end
endmodule
`default_nettype wire

/* testbench/rpu_core_properties.sv */
// Concurrent checks on the region protection unit ports.
`timescale 1ns/1ns
`default_nettype none
module rpu_core_chk
  import rpu_pkg::*;
(
  input wire logic            mclk,
  input wire logic            srst,
  input wire logic            cpValid,
  input wire logic            cpWrite,
  input wire logic [3:0]      cpCrn,
  input wire logic [2:0]      cpOpc2,
  input wire logic [31:0]     cpWdata,
  input wire logic [31:0]     cpRdata,
  input wire logic            instReq,
  input wire logic            instCachable,
  input wire logic            instAbort,
  input wire logic            dataReq,
  input wire logic            dataCachable,
  input wire logic            dataBufferable,
  input wire rpu_cache_mode_t dataCacheMode,
  input wire logic            dataAbort,
  input wire logic            unitActive
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  logic ctlWr;
  logic wEn;
  assign ctlWr = cpValid && cpWrite && cpCrn == RPU_CRN_CTRL;
  assign wEn = cpWdata[RPU_CTRL_EN_BIT];
  property p_ctrl_set;
    ctlWr |=> unitActive == $past(wEn);
  endproperty
  a_ctrl_set: assert property (p_ctrl_set)
    else $error("control enable not taken");
  property p_ctrl_hold;
    !ctlWr |=> $stable(unitActive);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold)
    else $error("unit state moved without a control write");
  property p_off;
    !unitActive |-> !(instCachable || dataCachable || dataBufferable
                      || instAbort || dataAbort);
  endproperty
  a_off: assert property (p_off)
    else $error("attributes or abort while unit is off");
  property p_mode;
    dataCacheMode == rpu_cache_mode_t'({dataCachable, dataBufferable});
  endproperty
  a_mode: assert property (p_mode)
    else $error("cache mode disagrees with attribute bits");
  property p_iabt;
    instAbort |-> instReq;
  endproperty
  a_iabt: assert property (p_iabt)
    else $error("prefetch abort without a fetch");
  property p_dabt;
    dataAbort |-> dataReq;
  endproperty
  a_dabt: assert property (p_dabt)
    else $error("data abort without an access");
  property p_rst;
    $fell(srst) |-> !unitActive && cpRdata == RPU_WORD_RESET;
  endproperty
  a_rst: assert property (p_rst)
    else $error("state not cleared by reset");
  property p_rd_hold;
    !(cpValid && !cpWrite) |=> $stable(cpRdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_reg_gap;
    cpValid && !cpWrite && cpCrn == RPU_CRN_REGION |=> cpRdata[11:6] == 6'h00;
  endproperty
  a_reg_gap: assert property (p_reg_gap)
    else $error("unused region bits read nonzero");
  property p_ibuf_zero;
    cpValid && !cpWrite && cpCrn == RPU_CRN_BUF && cpOpc2 == RPU_OPC2_INST
    |=> cpRdata == RPU_WORD_RESET;
  endproperty
  a_ibuf_zero: assert property (p_ibuf_zero)
    else $error("instruction set read back a bufferable bit");
  c_dabt: cover property (dataAbort);
  c_iabt: cover property (instAbort);
  c_wb: cover property (dataCacheMode == RPU_WB && !dataAbort);
endmodule
bind rpu_core rpu_core_chk u_chk (
  .mclk, .srst, .cpValid, .cpWrite, .cpCrn, .cpOpc2, .cpWdata, .cpRdata,
  .instReq, .instCachable, .instAbort, .dataReq, .dataCachable,
  .dataBufferable, .dataCacheMode, .dataAbort, .unitActive
);
`default_nettype wire

/* testbench/rpu_cpu_model.sv */
// Processor core model that issues fetch and data addresses.
`timescale 1ns/1ns
`default_nettype none
module rpu_cpu_model (
  input  wire logic   mclk,
  output logic        instReq,
  output logic [31:0] instAddr,
  output logic        instPriv,
  output logic        dataReq,
  output logic [31:0] dataAddr,
  output logic        dataPriv,
  output logic        dataWrite
);
  initial begin
    {instReq, instPriv, dataReq, dataPriv, dataWrite} = 5'h00;
    instAddr = 32'h00000000;
    dataAddr = 32'h00000000;
  end
  // Released address lines are inverted so a stale value never passes.
  task automatic access(input logic d, input logic [31:0] a,
                        input logic p, input logic w);
    @(posedge mclk);
    #1;
    if (d) begin
      {dataReq, dataAddr, dataPriv, dataWrite} = {1'b1, a, p, w};
    end else begin
      {instReq, instAddr, instPriv} = {1'b1, a, p};
    end
    @(posedge mclk);
    #1;
    {instReq, dataReq} = 2'h0;
    instAddr = ~instAddr;
    dataAddr = ~dataAddr;
  endtask
endmodule
`default_nettype wire
